// [inc/fsp_pkg.sv]
`default_nettype none

package fsp_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SCRATCH_0     = 8'hb0;
    localparam logic [7:0] CMD_SCRATCH_1     = 8'hb1;
    localparam logic [7:0] CMD_SCRATCH_2     = 8'hb2;
    localparam logic [7:0] CMD_SCRATCH_3     = 8'hb3;
    localparam logic [7:0] CMD_SCRATCH_4     = 8'hb4;
    localparam logic [7:0] CMD_LINE_RESPONSE = 8'hd5;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int SCRATCH_WORDS = 5;
    localparam int WORD_W        = 16;
    localparam int BYTE_W        = 8;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]  RESPONSE_RESET     = 8'hc0;
    localparam logic [15:0] SCRATCH_USER_RESET = 16'h0000;
    // words 0..2 have no defined default; a plain value is used
    localparam logic [15:0] SCRATCH_OEM_RESET  = 16'h0000;

    // ------------------------------------------------------------------
    // response setting values and decode field
    // ------------------------------------------------------------------
    localparam logic [7:0] RESPONSE_INHIBIT = 8'hc0;
    localparam logic [7:0] RESPONSE_IGNORE  = 8'h00;
    localparam int         RESPONSE_SEL_HI  = 7;
    localparam int         RESPONSE_SEL_LO  = 6;

    // ------------------------------------------------------------------
    // propagate mask bit positions
    // ------------------------------------------------------------------
    localparam int MASK_W          = 5;
    localparam int MASK_INPUT_OV   = 4;
    localparam int MASK_OUTPUT_OC  = 2;
    localparam int MASK_OUTPUT_UV  = 1;
    localparam int MASK_OUTPUT_OV  = 0;

    // ------------------------------------------------------------------
    // channel configuration bit that mutes the alert
    // ------------------------------------------------------------------
    localparam int CHAN_CFG_W          = 8;
    localparam int CHAN_CFG_ALERT_MUTE = 1;

    // ------------------------------------------------------------------
    // shared line observer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FSP_LINE_RELEASED,
        FSP_LINE_OWN_DRIVE,
        FSP_LINE_EXT_LOW
    } fsp_line_e;

endpackage : fsp_pkg

`default_nettype wire

// [hdl/fsp_line_sense.sv]
`default_nettype none

module fsp_line_sense
    import fsp_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // shared line
    input  wire logic line_in,
    input  wire logic own_drive,
    // observations
    output logic      ext_low
);

    // ------------------------------------------------------------------
    // observer state
    // ------------------------------------------------------------------
    fsp_line_e state_q;
    fsp_line_e state_d;

    // while we pull the line ourselves an outside low cannot be seen
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FSP_LINE_RELEASED: begin
                if (own_drive) begin
                    state_d = FSP_LINE_OWN_DRIVE;
                end else if (!line_in) begin
                    state_d = FSP_LINE_EXT_LOW;
                end
            end
            FSP_LINE_OWN_DRIVE: begin
                if (!own_drive && !line_in) begin
                    state_d = FSP_LINE_EXT_LOW;
                end else if (!own_drive) begin
                    state_d = FSP_LINE_RELEASED;
                end
            end
            FSP_LINE_EXT_LOW: begin
                if (own_drive) begin
                    state_d = FSP_LINE_OWN_DRIVE;
                end else if (line_in) begin
                    state_d = FSP_LINE_RELEASED;
                end
            end
            default: begin
                state_d = FSP_LINE_RELEASED;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= FSP_LINE_RELEASED;
        end else begin
            state_q <= state_d;
        end
    end

    assign ext_low = (state_q == FSP_LINE_EXT_LOW);

endmodule // fsp_line_sense

`default_nettype wire

// [hdl/fsp_fault_share.sv]
`default_nettype none

module fsp_fault_share
    import fsp_pkg::*;
#(
    parameter int N_WORDS = SCRATCH_WORDS
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,

    // command port behind the serial interface
    input  wire logic [7:0]            cmd_code,
    input  wire logic                  cmd_wr,
    input  wire logic [WORD_W-1:0]     cmd_wr_data,
    input  wire logic                  cmd_rd,
    output logic      [WORD_W-1:0]     cmd_rd_data,
    output logic                       cmd_rd_valid,
    output logic                       cmd_unsupported,

    // propagate mask
    input  wire logic                  share_input_overvoltage_en,
    input  wire logic                  share_output_overcurrent_en,
    input  wire logic                  share_output_undervoltage_en,
    input  wire logic                  share_output_overvoltage_en,

    // channel configuration and status clearing
    input  wire logic [CHAN_CFG_W-1:0] channel_configuration,
    input  wire logic                  clear_faults,

    // fault sources from the supervisors
    input  wire logic                  input_overvoltage_fault,
    input  wire logic                  output_overcurrent_fault,
    input  wire logic                  output_undervoltage_fault,
    input  wire logic                  output_overvoltage_fault,
    input  wire logic                  output_steady_on,

    // shared open-drain fault line
    input  wire logic                  fault_line_in,
    output logic                       fault_line_out,
    output logic                       fault_line_oe,

    // power stage
    output logic                       power_output_tristate,

    // status and alert
    output logic                       other_fault_summary_bit,
    output logic                       status_word_mfr_bit,
    output logic                       status_mfr_fault_line_bit,
    output logic                       alert_out,
    output logic                       alert_oe
);

    // ------------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] scratch_q [N_WORDS];
    logic [WORD_W-1:0] scratch_d [N_WORDS];
    logic [BYTE_W-1:0] response_q;
    logic [BYTE_W-1:0] response_d;
    logic [WORD_W-1:0] rd_data_q;
    logic [WORD_W-1:0] rd_data_d;
    logic              rd_valid_q;
    logic              rd_valid_d;
    logic              unsup_q;
    logic              unsup_d;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic              hit_response;
    logic              hit_scratch;
    logic [2:0]        scratch_idx;

    always_comb begin
        hit_response = (cmd_code == CMD_LINE_RESPONSE);
        hit_scratch  = 1'b0;
        scratch_idx  = 3'd0;
        unique case (cmd_code)
            CMD_SCRATCH_0: begin
                hit_scratch = 1'b1;
                scratch_idx = 3'd0;
            end
            CMD_SCRATCH_1: begin
                hit_scratch = 1'b1;
                scratch_idx = 3'd1;
            end
            CMD_SCRATCH_2: begin
                hit_scratch = 1'b1;
                scratch_idx = 3'd2;
            end
            CMD_SCRATCH_3: begin
                hit_scratch = 1'b1;
                scratch_idx = 3'd3;
            end
            CMD_SCRATCH_4: begin
                hit_scratch = 1'b1;
                scratch_idx = 3'd4;
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // a one-byte setting takes the low byte of the written word
    always_comb begin
        response_d = response_q;
        if (cmd_wr && hit_response) begin
            response_d = cmd_wr_data[BYTE_W-1:0];
        end
    end

    generate
        for (genvar i = 0; i < N_WORDS; i++) begin : g_scratch
            always_comb begin
                scratch_d[i] = scratch_q[i];
                if (cmd_wr && hit_scratch && (scratch_idx == 3'(i))) begin
                    scratch_d[i] = cmd_wr_data;
                end
            end

            // words 3 and 4 reset to zero, the others to a plain value
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    scratch_q[i] <= (i >= 3) ? SCRATCH_USER_RESET
                                             : SCRATCH_OEM_RESET;
                end else begin
                    scratch_q[i] <= scratch_d[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read answer, one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rd_data_d  = '0;
        rd_valid_d = 1'b0;
        unsup_d    = 1'b0;
        if (cmd_rd || cmd_wr) begin
            if (!(hit_response || hit_scratch)) begin
                unsup_d = 1'b1;
            end
        end
        if (cmd_rd) begin
            rd_valid_d = 1'b1;
            if (hit_response) begin
                rd_data_d = {{(WORD_W-BYTE_W){1'b0}}, response_q};
            end else if (hit_scratch) begin
                rd_data_d = scratch_q[scratch_idx];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            response_q <= RESPONSE_RESET;
            rd_data_q  <= '0;
            rd_valid_q <= 1'b0;
            unsup_q    <= 1'b0;
        end else begin
            response_q <= response_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            unsup_q    <= unsup_d;
        end
    end

    assign cmd_rd_data     = rd_data_q;
    assign cmd_rd_valid    = rd_valid_q;
    assign cmd_unsupported = unsup_q;

    // ------------------------------------------------------------------
    // fault propagation onto the shared line
    // ------------------------------------------------------------------
    logic [MASK_W-1:0] share_mask;
    logic [MASK_W-1:0] source_active;
    logic              uv_qualified;
    logic              line_drive_q;
    logic              line_drive_d;

    // undervoltage during ramp or off is expected, not a fault
    assign uv_qualified = output_undervoltage_fault
                        & output_steady_on;

    always_comb begin
        share_mask                 = '0;
        share_mask[MASK_INPUT_OV]  = share_input_overvoltage_en;
        share_mask[MASK_OUTPUT_OC] = share_output_overcurrent_en;
        share_mask[MASK_OUTPUT_UV] = share_output_undervoltage_en;
        share_mask[MASK_OUTPUT_OV] = share_output_overvoltage_en;
        source_active                 = '0;
        source_active[MASK_INPUT_OV]  = input_overvoltage_fault;
        source_active[MASK_OUTPUT_OC] = output_overcurrent_fault;
        source_active[MASK_OUTPUT_UV] = uv_qualified;
        source_active[MASK_OUTPUT_OV] = output_overvoltage_fault;
    end

    // level follow: released the cycle after the last enabled source ends
    always_comb begin
        line_drive_d = |(share_mask & source_active);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            line_drive_q <= 1'b0;
        end else begin
            line_drive_q <= line_drive_d;
        end
    end

    assign fault_line_out = 1'b0;
    assign fault_line_oe  = line_drive_q;

    // ------------------------------------------------------------------
    // outside low detection
    // ------------------------------------------------------------------
    logic ext_low;

    fsp_line_sense u_line_sense (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .line_in   (fault_line_in),
        .own_drive (line_drive_q),
        .ext_low   (ext_low)
    );

    // ------------------------------------------------------------------
    // reaction to an outside low
    // ------------------------------------------------------------------
    logic inhibit_mode;
    logic tristate_q;
    logic tristate_d;

    // only the two top bits select; 0xc0 inhibits, 0x00 ignores
    assign inhibit_mode =
        &response_q[RESPONSE_SEL_HI:RESPONSE_SEL_LO];

    always_comb begin
        tristate_d = ext_low && inhibit_mode;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tristate_q <= 1'b0;
        end else begin
            tristate_q <= tristate_d;
        end
    end

    assign power_output_tristate = tristate_q;

    // ------------------------------------------------------------------
    // sticky status and alert
    // ------------------------------------------------------------------
    logic other_q;
    logic other_d;
    logic word_mfr_q;
    logic word_mfr_d;
    logic mfr_line_q;
    logic mfr_line_d;
    logic alert_q;
    logic alert_d;
    logic alert_mute;

    assign alert_mute = channel_configuration[CHAN_CFG_ALERT_MUTE];

    // set is the held level, so a clear during a held low is undone at
    // once; set wins over clear in the same cycle
    always_comb begin
        other_d    = other_q;
        word_mfr_d = word_mfr_q;
        mfr_line_d = mfr_line_q;
        alert_d    = alert_q;
        if (clear_faults) begin
            other_d    = 1'b0;
            word_mfr_d = 1'b0;
            mfr_line_d = 1'b0;
            alert_d    = 1'b0;
        end
        if (ext_low) begin
            other_d    = 1'b1;
            word_mfr_d = 1'b1;
            mfr_line_d = 1'b1;
            if (!alert_mute) begin
                alert_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            other_q    <= 1'b0;
            word_mfr_q <= 1'b0;
            mfr_line_q <= 1'b0;
            alert_q    <= 1'b0;
        end else begin
            other_q    <= other_d;
            word_mfr_q <= word_mfr_d;
            mfr_line_q <= mfr_line_d;
            alert_q    <= alert_d;
        end
    end

    assign other_fault_summary_bit   = other_q;
    assign status_word_mfr_bit       = word_mfr_q;
    assign status_mfr_fault_line_bit = mfr_line_q;

    // alert is open drain, active low
    assign alert_out = 1'b0;
    assign alert_oe  = alert_q;

endmodule // fsp_fault_share

`default_nettype wire

// [verification/fsp_fault_share_asserts.sv]
`default_nettype none

module fsp_fault_share_chk
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    // command port
    input wire logic [7:0]        cmd_code,
    input wire logic              cmd_wr,
    input wire logic [WORD_W-1:0] cmd_wr_data,
    input wire logic              cmd_rd,
    input wire logic [WORD_W-1:0] cmd_rd_data,
    input wire logic              cmd_rd_valid,
    input wire logic              cmd_unsupported,
    // mask, sources and config
    input wire logic              share_input_overvoltage_en,
    input wire logic              share_output_overcurrent_en,
    input wire logic              share_output_undervoltage_en,
    input wire logic              share_output_overvoltage_en,
    input wire logic              input_overvoltage_fault,
    input wire logic              output_overcurrent_fault,
    input wire logic              output_undervoltage_fault,
    input wire logic              output_overvoltage_fault,
    input wire logic              output_steady_on,
    input wire logic [7:0]        channel_configuration,
    // line, power and status
    input wire logic              fault_line_in,
    input wire logic              fault_line_oe,
    input wire logic              power_output_tristate,
    input wire logic              other_fault_summary_bit,
    input wire logic              status_word_mfr_bit,
    input wire logic              status_mfr_fault_line_bit,
    input wire logic              alert_oe
);
    // ------------------------------------------------------------------
    // shadow of the response setting
    // ------------------------------------------------------------------
    logic [7:0] resp_q;
    logic [7:0] resp_d;
    logic       uv_q;
    logic       src;
    logic       ext;
    logic       known;
    logic       inhibit;

    always_comb begin
        resp_d = resp_q;
        if (cmd_wr && cmd_code == CMD_LINE_RESPONSE) begin
            resp_d = cmd_wr_data[7:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        resp_q <= sys_rst ? RESPONSE_RESET : resp_d;
    end
    assign uv_q    = output_undervoltage_fault && output_steady_on;
    assign src     = (input_overvoltage_fault && share_input_overvoltage_en)
                  || (output_overcurrent_fault && share_output_overcurrent_en)
                  || (uv_q && share_output_undervoltage_en)
                  || (output_overvoltage_fault && share_output_overvoltage_en);
    assign ext     = !fault_line_in && !fault_line_oe;
    assign known   = (cmd_code >= CMD_SCRATCH_0 && cmd_code <= CMD_SCRATCH_4)
                  || cmd_code == CMD_LINE_RESPONSE;
    assign inhibit = (resp_q[7:6] == 2'h3);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_ovin_pulls: assert property (
        input_overvoltage_fault && share_input_overvoltage_en
        |=> fault_line_oe) else $error("input ov not shared");
    a_oc_pulls: assert property (
        output_overcurrent_fault && share_output_overcurrent_en
        |=> fault_line_oe) else $error("overcurrent not shared");
    a_uv_pulls: assert property (
        uv_q && share_output_undervoltage_en
        |=> fault_line_oe) else $error("undervoltage not shared");
    a_ovout_pulls: assert property (
        output_overvoltage_fault && share_output_overvoltage_en
        |=> fault_line_oe) else $error("output ov not shared");
    a_line_release: assert property (
        !src |=> !fault_line_oe) else $error("line held, no source");
    a_inhibit_tristate: assert property (
        ext && inhibit |-> ##2 power_output_tristate)
        else $error("no three-state");
    a_ignore_keeps_on: assert property (
        (!inhibit) [*3] |-> !power_output_tristate)
        else $error("ignore three-stated");
    a_status_sets: assert property (
        ext |-> ##2 (other_fault_summary_bit && status_word_mfr_bit
                     && status_mfr_fault_line_bit))
        else $error("status not set");
    a_alert_raise: assert property (
        ext && !channel_configuration[1] |-> ##2 alert_oe)
        else $error("alert not raised");
    a_alert_muted: assert property (
        channel_configuration[1] && !alert_oe |=> !alert_oe)
        else $error("alert while muted");
    a_read_answer: assert property (
        cmd_rd && known |=> cmd_rd_valid && !cmd_unsupported)
        else $error("read not answered");
    a_resp_readback: assert property (
        cmd_rd && cmd_code == CMD_LINE_RESPONSE
        |=> cmd_rd_data == {8'h00, $past(resp_q)})
        else $error("readback wrong");
    a_unknown_refused: assert property (
        (cmd_rd || cmd_wr) && !known |=> cmd_unsupported && cmd_rd_data == 0)
        else $error("unknown not refused");

    c_tristate: cover property (power_output_tristate);
    c_alert: cover property (alert_oe);
    c_unsupported: cover property (cmd_unsupported);
    c_uv_shared: cover property (fault_line_oe && output_undervoltage_fault);
endmodule // fsp_fault_share_chk

bind fsp_fault_share fsp_fault_share_chk u_chk (.*);

`default_nettype wire

// [verification/fsp_peer_ctrl.sv]
`default_nettype none

// another controller on the shared line; pulls it low after lag cycles
module fsp_peer_ctrl (
    // clock
    input  wire logic       sys_clk,
    // request and speed
    input  wire logic       pull_req,
    input  wire logic [3:0] lag,
    // open-drain enable
    output logic            pull_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q = 4'h0;
    logic [3:0] cnt_d;

    always_comb begin
        cnt_d = 4'h0;
        if (pull_req) begin
            cnt_d = (cnt_q == lag) ? cnt_q : cnt_q + 4'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        cnt_q <= cnt_d;
    end
    // immediate release, no lag
    assign pull_oe = pull_req && (cnt_q == lag);
endmodule // fsp_peer_ctrl

`default_nettype wire

// [verification/tb_fault_share_pin_logic.sv]
`default_nettype none

module tb_fault_share_pin_logic import fsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic              sys_clk = 1'h0;
    logic              sys_rst = 1'h1;
    logic [7:0]        cmd_code = 8'h00;
    logic              cmd_wr = 1'h0;
    logic              cmd_rd = 1'h0;
    logic [WORD_W-1:0] cmd_wr_data = 16'h0000;
    logic [WORD_W-1:0] cmd_rd_data;
    logic              cmd_rd_valid, cmd_unsupported;
    // bit 3 input ov, 2 overcurrent, 1 undervoltage, 0 output ov
    logic [3:0]        en = 4'h0;
    logic [3:0]        flt = 4'h0;
    logic              output_steady_on = 1'h1;
    logic [7:0]        channel_configuration = 8'h00;
    logic              clear_faults = 1'h0;
    logic              peer_req = 1'h0;
    logic [3:0]        peer_lag = 4'h0;
    logic              peer_oe, fault_line_in, fault_line_oe, fault_line_out;
    logic              power_output_tristate, alert_oe, alert_out;
    logic              other_fault_summary_bit, status_word_mfr_bit;
    logic              status_mfr_fault_line_bit;
    int                mismatches = 0;
    int                n_compared = 0;

    // open-drain line with pull-up
    assign fault_line_in = !((fault_line_oe && !fault_line_out) || peer_oe);
    always #10 sys_clk = ~sys_clk;

    fsp_fault_share dut (
        .sys_clk, .sys_rst, .cmd_code, .cmd_wr, .cmd_wr_data, .cmd_rd,
        .cmd_rd_data, .cmd_rd_valid, .cmd_unsupported,
        .share_input_overvoltage_en(en[3]),
        .share_output_overcurrent_en(en[2]),
        .share_output_undervoltage_en(en[1]),
        .share_output_overvoltage_en(en[0]),
        .channel_configuration, .clear_faults,
        .input_overvoltage_fault(flt[3]), .output_overcurrent_fault(flt[2]),
        .output_undervoltage_fault(flt[1]), .output_overvoltage_fault(flt[0]),
        .output_steady_on, .fault_line_in, .fault_line_out,
        .fault_line_oe, .power_output_tristate, .other_fault_summary_bit,
        .status_word_mfr_bit, .status_mfr_fault_line_bit,
        .alert_out, .alert_oe
    );
    fsp_peer_ctrl peer (
        .sys_clk, .pull_req(peer_req), .lag(peer_lag), .pull_oe(peer_oe)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d);
        cmd_code = c;
        cmd_wr_data = d;
        cmd_wr = 1'h1;
        cyc(1);
        cmd_wr = 1'h0;
    endtask
    task rd(input logic [7:0] c, output logic [15:0] d, output logic [1:0] vu);
        cmd_code = c;
        cmd_rd = 1'h1;
        cyc(1);
        cmd_rd = 1'h0;
        d = cmd_rd_data;
        vu = {cmd_rd_valid, cmd_unsupported};
    endtask
    task wait_tri(input logic exp);
        int k;
        for (k = 0; k < 12 && power_output_tristate !== exp; k++) cyc(1);
        if (power_output_tristate !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: tristate timeout", $time);
            print_verdict();
        end
    endtask
    function automatic logic [15:0] stat4();
        return {12'h000, other_fault_summary_bit, status_word_mfr_bit,
                status_mfr_fault_line_bit, alert_oe && !alert_out};
    endfunction

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        logic [7:0]  codes [6];
        logic [15:0] d;
        logic [1:0]  vu;
        codes = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hd5};
        for (int i = 0; i < 6; i++) begin
            rd(codes[i], d, vu);
            check(d, (i == 5) ? 16'h00c0 : 16'h0000);
            check(16'(vu), 16'h0002);
            cyc(1);
        end
        for (int i = 0; i < 6; i++) begin
            wr(codes[i], {codes[i], ~codes[i]});
            rd(codes[i], d, vu);
            check(d, {i == 5 ? 8'h0 : codes[i], ~codes[i]});
            cyc(1);
        end
        wr(8'hb5, 16'hffff);
        rd(8'hb5, d, vu);
        check(d, 16'h0000);
        check(16'(vu[0]), 16'h0001);
        wr(CMD_LINE_RESPONSE, 16'h00c0);
        $display("test registers done");
    endtask

    task t_propagate;
        for (int i = 0; i < 4; i++) begin
            for (int e = 0; e < 2; e++) begin
                en = (e == 1) ? (4'h1 << i) : ~(4'h1 << i);
                flt = 4'h1 << i;
                cyc(1);
                check(16'(fault_line_oe), 16'(e));
                flt = 4'h0;
                cyc(1);
                check(16'(fault_line_oe), 16'h0000);
            end
        end
        en = 4'h2;
        output_steady_on = 1'h0;
        flt = 4'h2;
        cyc(3);
        check(16'(fault_line_oe), 16'h0000);
        output_steady_on = 1'h1;
        cyc(6);
        check(16'(fault_line_in), 16'h0000);
        flt = 4'h0;
        en = 4'h0;
        cyc(2);
        $display("test propagation done");
    endtask

    task t_inhibit;
        peer_lag = 4'h3;
        peer_req = 1'h1;
        wait_tri(1'h1);
        check(stat4(), 16'h000f);
        clear_faults = 1'h1;
        cyc(1);
        clear_faults = 1'h0;
        check(stat4(), 16'h000f);
        peer_req = 1'h0;
        wait_tri(1'h0);
        clear_faults = 1'h1;
        cyc(1);
        clear_faults = 1'h0;
        check(stat4(), 16'h0000);
        $display("test inhibit done");
    endtask

    task t_ignore;
        wr(CMD_LINE_RESPONSE, 16'h0000);
        channel_configuration = 8'h02;
        cyc(3);
        peer_req = 1'h1;
        cyc(6);
        check(16'(power_output_tristate), 16'h0000);
        check(stat4(), 16'h000e);
        peer_req = 1'h0;
        cyc(3);
        clear_faults = 1'h1;
        cyc(1);
        clear_faults = 1'h0;
        channel_configuration = 8'h00;
        check(stat4(), 16'h0000);
        $display("test ignore done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(5);
        sys_rst = 1'h0;
        cyc(1);
        t_regs();
        t_propagate();
        t_inhibit();
        t_ignore();
        print_verdict();
    end
endmodule // tb_fault_share_pin_logic

`default_nettype wire
